/* File: bench/fpk_keypad_menu_monitor.sv */
// Purpose: port assertions for the keypad menu block
// Assumes: one clock, synchronous active-high reset
// Notes:   bound to every instance of the top module
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// checker
// ************************************************************
module fpk_keypad_menu_monitor (
   input wire logic REF_CLK,
   input wire logic RST,
   input wire logic KEY_RUN,
   input wire logic LED_RUN_EN,
   input wire logic LED_HZ,
   input wire logic LED_AMP,
   input wire logic LED_ALARM,
   input wire logic ALARM_RELAY,
   input wire logic RUN_FWD,
   input wire logic RUN_REV,
   input wire logic STOP_CMD,
   input wire logic TRIP_RESET,
   input wire logic EDIT_STATE_INDICATOR,
   input wire logic NVM_WRITE
);
   default clocking cb @(posedge REF_CLK);
   endclocking
   default disable iff (RST);
   // indicator relations
   a_alarm_relay_tie: assert property (LED_ALARM == ALARM_RELAY)
      else $error("alarm led and relay differ");
   a_units_one_lit: assert property (!$past(RST) |-> LED_HZ != LED_AMP)
      else $error("unit leds not exactly one");
   a_trip_blocks_run: assert property (LED_ALARM && $past(LED_ALARM) |-> !LED_RUN_EN)
      else $error("run key enabled during trip");
   // command pulses
   a_dir_exclusive: assert property (!(RUN_FWD && RUN_REV))
      else $error("both run directions at once");
   a_run_gated: assert property ((RUN_FWD || RUN_REV) |-> $past(LED_RUN_EN))
      else $error("run issued while key disabled");
   a_run_once: assert property (RUN_FWD |=> !RUN_FWD [*8])
      else $error("one press gave two run pulses");
   a_run_key_held: assert property ((RUN_FWD || RUN_REV) |-> $past(KEY_RUN, 2) && $past(KEY_RUN, 3))
      else $error("run pulse without held key");
   a_store_in_edit: assert property (NVM_WRITE |-> $past(EDIT_STATE_INDICATOR))
      else $error("store outside editing state");
   // main scenarios
   c_run: cover property (RUN_FWD);
   c_store: cover property (NVM_WRITE);
   c_clear: cover property (TRIP_RESET && STOP_CMD);
endmodule : fpk_keypad_menu_monitor
bind fpk_keypad_menu fpk_keypad_menu_monitor mon_u (.REF_CLK(REF_CLK), .RST(RST), .KEY_RUN(KEY_RUN),
   .LED_RUN_EN(LED_RUN_EN), .LED_HZ(LED_HZ), .LED_AMP(LED_AMP), .LED_ALARM(LED_ALARM),
   .ALARM_RELAY(ALARM_RELAY), .RUN_FWD(RUN_FWD), .RUN_REV(RUN_REV), .STOP_CMD(STOP_CMD),
   .TRIP_RESET(TRIP_RESET), .EDIT_STATE_INDICATOR(EDIT_STATE_INDICATOR), .NVM_WRITE(NVM_WRITE));
`default_nettype wire

/* File: bench/fpk_keypad_menu_tb.sv */
// Purpose: self-checking bench for the keypad menu block
// Assumes: zero-wait AHB-Lite slave, short debounce and test spans
// Notes:   command pulses are counted, then compared
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// testbench
// ************************************************************
module fpk_keypad_menu_tb;
   typedef struct packed {logic w; logic [7:0] a; logic [31:0] d; logic [31:0] e;} fpk_row_t;
   logic        clk = 1'b0, rst, hsel, hwrite;
   logic [31:0] haddr, hwdata, hrdata, r, v0;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic        hrdy, hresp, led_run, led_edit, led_en, led_pot, led_hz, led_amp, led_pwr, led_al, relay;
   logic        fwd, rev, stp, trst, nvw;
   logic [6:0]  seg;
   logic [3:0]  dig;
   logic [15:0] nvd;
   logic [7:0]  nva;
   logic [5:0]  keys;
   int          n_fwd = 0, n_rev = 0, n_stp = 0, n_trst = 0, n_nvw = 0;
   int          miscompares = 0, total_checks = 0;
   fpk_row_t    rows[8] = '{
      '{1'b0, 8'h00, 32'h0, 32'h1}, '{1'b0, 8'h04, 32'h0, 32'h1}, '{1'b0, 8'h0c, 32'h0, 32'h0},
      '{1'b0, 8'h10, 32'h0, 32'h0}, '{1'b1, 8'h20, 32'hff, 32'h0}, '{1'b0, 8'h20, 32'h0, 32'h0},
      '{1'b1, 8'h00, 32'h2, 32'h0}, '{1'b0, 8'h00, 32'h0, 32'h2}};
   always #10 clk = ~clk;
   fpk_keypad_menu #(.DEBOUNCE_CYC(4), .TEST_CYC(10)) dut_u (.REF_CLK(clk), .RST(rst), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hrdy),
      .HRDATA(hrdata), .HREADYOUT(hrdy), .HRESP(hresp), .KEY_FUNC(keys[0]), .KEY_UP(keys[1]),
      .KEY_DOWN(keys[2]), .COMMIT_KEY(keys[3]), .KEY_RUN(keys[4]), .KEY_STOP(keys[5]), .SEG(seg),
      .DIGIT_EN(dig), .LED_RUN(led_run), .EDIT_STATE_INDICATOR(led_edit), .LED_RUN_EN(led_en),
      .LED_POT(led_pot), .LED_HZ(led_hz), .LED_AMP(led_amp), .LED_POWER(led_pwr), .LED_ALARM(led_al),
      .ALARM_RELAY(relay), .RUN_FWD(fwd), .RUN_REV(rev), .STOP_CMD(stp), .TRIP_RESET(trst),
      .NVM_WRITE(nvw), .NVM_DATA(nvd), .NVM_ADDR(nva));
   fpk_operator op_u (.clk(clk), .keys(keys));
   // pulse counters
   always @(posedge clk) begin
      n_fwd <= n_fwd + (fwd === 1'b1);
      n_rev <= n_rev + (rev === 1'b1);
      n_stp <= n_stp + (stp === 1'b1);
      n_trst <= n_trst + (trst === 1'b1);
      n_nvw <= n_nvw + (nvw === 1'b1);
   end
   task automatic chk(input logic [63:0] g, input logic [63:0] e);
      total_checks++;
      if (g !== e) begin
         miscompares++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask : chk
   // one single AHB-Lite transfer, waits on hready
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
      @(posedge clk);
      hsel <= 1'b1;
      haddr <= {24'h0, a};
      hwrite <= w;
      hsize <= 3'h2;
      htrans <= 2'h2;
      do @(posedge clk); while (hrdy !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hrdy !== 1'b1);
      q = hrdata;
   endtask : bus
   task automatic close_out();
      $display("checks=%0d mismatches=%0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : close_out
   // watchdog
   initial begin
      #400000;
      miscompares++;
      close_out();
   end
   // main sequence
   initial begin
      rst <= 1'b1;
      {hsel, hwrite, htrans, hsize, haddr, hwdata} <= '0;
      repeat (12) @(posedge clk);
      chk({hrdy, hresp, led_pwr, led_run}, 4'h8);
      rst <= 1'b0;
      repeat (3) @(posedge clk);
      chk({led_pwr, led_hz, led_amp}, 3'h6);
      chk(seg, fpk_pkg::SEG_ALL);
      repeat (30) @(posedge clk);
      chk({dig, seg}, {4'h1, 7'h3f});
      // register rows
      foreach (rows[i]) begin
         bus(rows[i].w, rows[i].a, rows[i].d, r);
         if (!rows[i].w) chk(r, rows[i].e);
      end
      // each run source; only keypad accepts the key
      for (int s = 1; s <= 3; s++) begin
         bus(1'b1, 8'h00, s, r);
         repeat (3) @(posedge clk);
         chk(led_en, s == 2);
         op_u.press(4);
         chk(n_fwd, s >= 2);
      end
      bus(1'b1, 8'h00, 32'h6, r);
      op_u.press(4);
      chk({n_fwd, n_rev}, {32'd1, 32'd1});
      // browse into the main profile group, then edit
      op_u.press(0);
      op_u.press(1);
      bus(1'b0, 8'h0c, 32'h0, r);
      chk(r, 32'h10);
      chk(led_edit, 1'b1);
      op_u.press(0);
      bus(1'b0, 8'h04, 32'h0, r);
      chk(r[2:0], 3'h3);
      bus(1'b0, 8'h08, 32'h0, v0);
      op_u.press(1);
      op_u.press(3);
      chk(n_nvw, 1);
      chk({nva, nvd}, {8'h10, v0[15:0] + 16'h1});
      bus(1'b0, 8'h08, 32'h0, r);
      chk(r, v0 + 32'h1);
      op_u.press(0);
      op_u.press(1);
      op_u.press(0);
      bus(1'b0, 8'h08, 32'h0, r);
      chk({n_nvw, r}, {32'd1, v0 + 32'h1});
      // running with knob selected
      bus(1'b1, 8'h00, 32'h2a, r);
      repeat (3) @(posedge clk);
      chk({led_run, led_pot}, 2'h3);
      bus(1'b1, 8'h00, 32'h2, r);
      repeat (3) @(posedge clk);
      chk({led_run, led_pot}, 2'h0);
      // trip, refused run, stop clears
      bus(1'b1, 8'h00, 32'h332, r);
      repeat (3) @(posedge clk);
      chk({led_al, relay, led_en}, 3'h6);
      bus(1'b0, 8'h04, 32'h0, r);
      chk(r[2:0], 3'h4);
      chk(seg, 7'h4f);
      op_u.press(4);
      chk(n_fwd, 1);
      op_u.press(5);
      chk({n_stp, n_trst}, {32'd1, 32'd1});
      bus(1'b1, 8'h00, 32'h2, r);
      repeat (3) @(posedge clk);
      chk({led_al, relay}, 2'h0);
      // second reset after stop
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      bus(1'b0, 8'h00, 32'h0, r);
      chk(r, 32'h1);
      close_out();
   end
endmodule : fpk_keypad_menu_tb
`default_nettype wire

/* File: bench/fpk_operator.sv */
// Purpose: operator model pressing front panel keys
// Assumes: keys are active-high levels sampled on clk
// Notes:   index 0 func, 1 up, 2 down, 3 store, 4 run, 5 stop
`timescale 1ns/1ns
`default_nettype none
// ************************************************************
// operator
// ************************************************************
module fpk_operator #(
   parameter int HOLD = 8
) (
   input wire logic       clk,
   output logic     [5:0] keys
);
   logic [5:0] down = 6'h00; // keys the operator holds down
   // keys move only on a rising clock edge
   always @(posedge clk) begin
      keys <= down;
   end
   // press and release, each outlasting the debounce span
   task automatic press(input int k);
      @(posedge clk);
      down[k] <= 1'b1;
      repeat (HOLD) @(posedge clk);
      down[k] <= 1'b0;
      repeat (HOLD) @(posedge clk);
   endtask : press
endmodule : fpk_operator
`default_nettype wire

/* File: hw/fpk_keypad_menu.sv */
// Purpose: front panel keypad, display and indicator logic for a motor drive
// Assumes: keys are synchronous active-high levels; motor core and nvm are outside
// Notes:   registers reached over AHB-Lite; one 32-bit word per register
`timescale 1ns/1ns
`default_nettype none
// What this block does
// [R1] run led follows active output stage
// [R2] program led lit while editing
// [R3] run-key led only when key accepted
// [R4] run key issues forward or reverse
// [R5] stop key stops motor, clears trip
// [R6] four seven-segment digits show codes
// [R7] exactly one of hertz or amps lit
// [R8] alarm led and relay follow trip
// [R9] store key writes edited value
// [R10] four-character codes grouped by letter
// [R11] monitor group enters monitoring state; function on a d-group code goes to ST_BROWSE, not ST_MONITOR
// [R12] other groups enter editing state
// [R13] fault shows error code automatically
// [R14] function moves across, up/down move/edit
// [R15] test pattern then zero hertz reading
// [R16] values change only while editing
// [R17] b and d shown lower case
// [R18] pot led when knob is source
// [R19] source codes 01 terminals 02 keypad 03 net
// [R20] each press debounced, one event
// [R21] unstored edit discarded on leaving
module fpk_keypad_menu #(
   parameter int DEBOUNCE_CYC = fpk_pkg::CLK_HZ / 1000 * fpk_pkg::DEBOUNCE_MS,
   parameter int TEST_CYC     = fpk_pkg::CLK_HZ / 1000 * fpk_pkg::TEST_MS
) (
   input  wire logic        REF_CLK,
   input  wire logic        RST,
   input  wire logic        HSEL,
   input  wire logic [31:0] HADDR,
   input  wire logic [1:0]  HTRANS,
   input  wire logic        HWRITE,
   input  wire logic [2:0]  HSIZE,
   input  wire logic [31:0] HWDATA,
   input  wire logic        HREADY,
   output logic      [31:0] HRDATA,
   output logic             HREADYOUT,
   output logic             HRESP,
   input  wire logic        KEY_FUNC,
   input  wire logic        KEY_UP,
   input  wire logic        KEY_DOWN,
   input  wire logic        COMMIT_KEY,
   input  wire logic        KEY_RUN,
   input  wire logic        KEY_STOP,
   output logic      [6:0]  SEG,
   output logic      [3:0]  DIGIT_EN,
   output logic             LED_RUN,
   output logic             EDIT_STATE_INDICATOR,
   output logic             LED_RUN_EN,
   output logic             LED_POT,
   output logic             LED_HZ,
   output logic             LED_AMP,
   output logic             LED_POWER,
   output logic             LED_ALARM,
   output logic             ALARM_RELAY,
   output logic             RUN_FWD,
   output logic             RUN_REV,
   output logic             STOP_CMD,
   output logic             TRIP_RESET,
   output logic             NVM_WRITE,
   output logic      [15:0] NVM_DATA,
   output logic      [7:0]  NVM_ADDR
);
   // ************************************************************
   // state
   // ************************************************************
   typedef enum {ST_TEST, ST_MONITOR, ST_BROWSE, ST_EDIT, ST_FAULT} fpk_state_t;
   fpk_state_t  state_q;
   logic [31:0] ctrl_q;
   logic [15:0] live_q;
   logic [15:0] values_q [0:95];
   logic [2:0]  grp_q;
   logic [3:0]  idx_q;
   logic [15:0] edit_q;
   logic        dirty_q;
   logic [31:0] test_cnt_q;
   logic [5:0]  key_raw;
   logic [5:0]  key_stable_q;
   logic [5:0]  key_press;
   logic [6:0]  vaddr;
   logic [15:0] scan_cnt_q;
   logic [1:0]  digit_q;
   logic [1:0]  src;
   logic        trip;
   logic        running;
   logic        run_key_ok;

   assign key_raw    = {KEY_STOP, KEY_RUN, COMMIT_KEY, KEY_DOWN, KEY_UP, KEY_FUNC};
   assign src        = ctrl_q[fpk_pkg::CTRL_SRC_LSB +: 2];
   assign trip       = ctrl_q[fpk_pkg::CTRL_TRIP_BIT];
   assign running    = ctrl_q[fpk_pkg::CTRL_RUN_BIT];
   assign run_key_ok = (src == fpk_pkg::SRC_KEYPAD) && !trip; // R19
   assign vaddr      = 7'({grp_q, idx_q});

   // ************************************************************
   // key debounce, one pulse per press
   // ************************************************************
   generate
      for (genvar k = 0; k < 6; k++) begin : g_key
         logic [31:0] cnt_q;
         logic        last_q;
         // count while input differs from stable level
         always_ff @(posedge REF_CLK) begin
            if (RST) begin
               cnt_q           <= 32'h0;
               key_stable_q[k] <= 1'b0;
            end else if (key_raw[k] == key_stable_q[k]) begin
               cnt_q <= 32'h0;
            end else if (cnt_q >= 32'(DEBOUNCE_CYC - 1)) begin
               cnt_q           <= 32'h0;
               key_stable_q[k] <= key_raw[k]; // R20
            end else begin
               cnt_q <= cnt_q + 32'h1;
            end
         end
         // rising edge of stable level
         always_ff @(posedge REF_CLK) begin
            if (RST) begin
               last_q <= 1'b0;
            end else begin
               last_q <= key_stable_q[k];
            end
         end
         assign key_press[k] = key_stable_q[k] & ~last_q; // R20
      end
   endgenerate

   // ************************************************************
   // AHB-Lite slave, zero wait state
   // ************************************************************
   logic       ap_wr_q;
   logic       ap_rd_q;
   logic [7:0] ap_addr_q;
   logic       ap_valid;
   assign ap_valid = HSEL && HREADY && HTRANS[1];

   // capture address phase
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ap_wr_q   <= 1'b0;
         ap_rd_q   <= 1'b0;
         ap_addr_q <= 8'h00;
      end else begin
         ap_wr_q   <= ap_valid && HWRITE;
         ap_rd_q   <= ap_valid && !HWRITE;
         ap_addr_q <= HADDR[7:0];
      end
   end

   // control register written by software
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         ctrl_q <= 32'h0000_0001;
      end else if (ap_wr_q && ap_addr_q == fpk_pkg::OFS_CTRL) begin
         ctrl_q <= HWDATA;
      end
   end

   // live frequency written by motor core software
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         live_q <= 16'h0000; // R15
      end else if (ap_wr_q && ap_addr_q == fpk_pkg::OFS_LIVE) begin
         live_q <= HWDATA[15:0];
      end
   end

   // read data, unmapped reads as zero
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         HRDATA <= 32'h0;
      end else if (ap_valid && !HWRITE) begin
         case (HADDR[7:0])
            fpk_pkg::OFS_CTRL:   HRDATA <= ctrl_q;
            fpk_pkg::OFS_STATUS: HRDATA <= {24'h0, dirty_q, EDIT_STATE_INDICATOR, LED_RUN_EN,
                                            LED_ALARM, 1'b0, 3'(state_q)};
            fpk_pkg::OFS_VALUE:  HRDATA <= {16'h0, values_q[vaddr]};
            fpk_pkg::OFS_CODE:   HRDATA <= {24'h0, 1'b0, grp_q, idx_q};
            fpk_pkg::OFS_LIVE:   HRDATA <= {16'h0, live_q};
            default:             HRDATA <= 32'h0;
         endcase
      end
   end

   // always ready, always okay
   always_ff @(posedge REF_CLK) begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
   end

   // ************************************************************
   // menu state machine
   // ************************************************************
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         state_q    <= ST_TEST;
         test_cnt_q <= 32'h0;
         grp_q      <= 3'(fpk_pkg::GRP_D);
         idx_q      <= 4'h0;
         edit_q     <= 16'h0;
         dirty_q    <= 1'b0;
      end else begin
         case (state_q)
            ST_TEST: begin
               if (test_cnt_q >= 32'(TEST_CYC - 1)) begin
                  state_q <= ST_MONITOR; // R15
               end else begin
                  test_cnt_q <= test_cnt_q + 32'h1;
               end
            end
            ST_MONITOR, ST_BROWSE: begin
               if (trip) begin
                  state_q <= ST_FAULT; // R13
               end else if (key_press[0]) begin
                  if (state_q == ST_BROWSE && grp_q != 3'(fpk_pkg::GRP_D)) begin
                     edit_q  <= values_q[vaddr];
                     dirty_q <= 1'b0;
                     state_q <= ST_EDIT; // R14
                  end else begin
                     state_q <= ST_BROWSE;
                  end
               end else if (key_press[1] || key_press[2]) begin
                  if (idx_q == 4'h0 && state_q == ST_BROWSE && key_press[1]) begin
                     grp_q <= (grp_q == fpk_pkg::GRP_LAST) ? 3'(fpk_pkg::GRP_D) : grp_q + 3'h1; // R14
                  end else if (key_press[1]) begin
                     idx_q <= idx_q + 4'h1;
                  end else begin
                     idx_q <= idx_q - 4'h1;
                  end
                  state_q <= ST_BROWSE;
               end
            end
            ST_EDIT: begin
               if (trip) begin
                  dirty_q <= 1'b0; // R21
                  state_q <= ST_FAULT;
               end else if (key_press[1]) begin
                  edit_q  <= edit_q + 16'h1; // R16
                  dirty_q <= 1'b1;
               end else if (key_press[2]) begin
                  edit_q  <= edit_q - 16'h1; // R16
                  dirty_q <= 1'b1;
               end else if (key_press[3] || key_press[0]) begin
                  dirty_q <= 1'b0; // R21
                  state_q <= ST_BROWSE;
               end
            end
            ST_FAULT: begin
               if (!trip) begin
                  state_q <= (grp_q == 3'(fpk_pkg::GRP_D)) ? ST_MONITOR : ST_BROWSE;
               end
            end
            default: state_q <= ST_MONITOR;
         endcase
      end
   end

   // value store and nvm write on commit
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         NVM_WRITE <= 1'b0;
         NVM_DATA  <= 16'h0;
         NVM_ADDR  <= 8'h00;
         values_q  <= '{default: 16'h0}; // no unknown value before the first store
      end else begin
         NVM_WRITE <= 1'b0;
         if (state_q == ST_EDIT && key_press[3] && dirty_q && !trip) begin
            values_q[vaddr] <= edit_q; // R9
            NVM_WRITE       <= 1'b1;   // R9
            NVM_DATA        <= edit_q;
            NVM_ADDR        <= {1'b0, vaddr};
         end
      end
   end

   // ************************************************************
   // run, stop and trip commands
   // ************************************************************
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         RUN_FWD    <= 1'b0;
         RUN_REV    <= 1'b0;
         STOP_CMD   <= 1'b0;
         TRIP_RESET <= 1'b0;
      end else begin
         RUN_FWD    <= key_press[4] && run_key_ok && !ctrl_q[fpk_pkg::CTRL_DIR_BIT]; // R4
         RUN_REV    <= key_press[4] && run_key_ok && ctrl_q[fpk_pkg::CTRL_DIR_BIT];  // R4
         STOP_CMD   <= key_press[5] && running; // R5
         TRIP_RESET <= key_press[5] && trip;    // R5
      end
   end

   // ************************************************************
   // indicators
   // ************************************************************
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         LED_RUN              <= 1'b0;
         EDIT_STATE_INDICATOR <= 1'b0;
         LED_RUN_EN           <= 1'b0;
         LED_POT              <= 1'b0;
         LED_HZ               <= 1'b0;
         LED_AMP              <= 1'b0;
         LED_POWER            <= 1'b0;
         LED_ALARM            <= 1'b0;
         ALARM_RELAY          <= 1'b0;
      end else begin
         LED_RUN              <= running; // R1
         EDIT_STATE_INDICATOR <= (state_q == ST_BROWSE || state_q == ST_EDIT)
                                 && grp_q != 3'(fpk_pkg::GRP_D); // R2 R11 R12
         LED_RUN_EN           <= run_key_ok; // R3
         LED_POT              <= ctrl_q[fpk_pkg::CTRL_POT_BIT]; // R18
         LED_HZ               <= !(state_q == ST_BROWSE && grp_q == 3'(fpk_pkg::GRP_D) && idx_q == 4'h2); // R7
         LED_AMP              <= state_q == ST_BROWSE && grp_q == 3'(fpk_pkg::GRP_D) && idx_q == 4'h2; // R7
         LED_POWER            <= 1'b1;
         LED_ALARM            <= trip; // R8
         ALARM_RELAY          <= trip; // R8
      end
   end

   // ************************************************************
   // display scan, four digits
   // ************************************************************
   function automatic logic [6:0] hex_seg(input logic [3:0] v);
      case (v)
         4'h0: hex_seg = 7'h3f;
         4'h1: hex_seg = 7'h06;
         4'h2: hex_seg = 7'h5b;
         4'h3: hex_seg = 7'h4f;
         4'h4: hex_seg = 7'h66;
         4'h5: hex_seg = 7'h6d;
         4'h6: hex_seg = 7'h7d;
         4'h7: hex_seg = 7'h07;
         4'h8: hex_seg = 7'h7f;
         4'h9: hex_seg = 7'h6f;
         default: hex_seg = 7'h40;
      endcase
   endfunction

   // group letter, b and d lower case
   function automatic logic [6:0] grp_seg(input logic [2:0] g);
      case (g)
         3'(fpk_pkg::GRP_D): grp_seg = 7'h5e; // R17
         3'(fpk_pkg::GRP_F): grp_seg = 7'h71;
         3'(fpk_pkg::GRP_A): grp_seg = 7'h77;
         3'(fpk_pkg::GRP_B): grp_seg = 7'h7c; // R17
         3'(fpk_pkg::GRP_C): grp_seg = 7'h39;
         3'(fpk_pkg::GRP_H): grp_seg = 7'h76;
         default:            grp_seg = 7'h79;
      endcase
   endfunction

   logic [15:0] shown;
   logic [6:0]  seg_d;
   // select what the four digits show
   always_comb begin
      shown = live_q;
      seg_d = fpk_pkg::SEG_BLANK;
      case (state_q)
         ST_TEST:    seg_d = fpk_pkg::SEG_ALL; // R15
         ST_MONITOR: shown = live_q;
         ST_EDIT:    shown = edit_q;
         ST_FAULT:   shown = {4'he, 8'h00, ctrl_q[fpk_pkg::CTRL_FLT_LSB +: 4]}; // R13
         default:    shown = {1'b0, grp_q, 8'h00, idx_q}; // R10
      endcase
      if (state_q != ST_TEST) begin
         if (digit_q == 2'h3 && (state_q == ST_BROWSE || state_q == ST_FAULT)) begin
            seg_d = (state_q == ST_FAULT) ? grp_seg(3'h6) : grp_seg(grp_q); // R10
         end else begin
            seg_d = hex_seg(shown[4*digit_q +: 4]); // R6
         end
      end
   end

   // digit multiplex
   always_ff @(posedge REF_CLK) begin
      if (RST) begin
         scan_cnt_q <= 16'h0;
         digit_q    <= 2'h0;
         SEG        <= fpk_pkg::SEG_BLANK;
         DIGIT_EN   <= 4'h0;
      end else begin
         if (scan_cnt_q >= 16'(fpk_pkg::SCAN_CYC - 1)) begin
            scan_cnt_q <= 16'h0;
            digit_q    <= digit_q + 2'h1;
         end else begin
            scan_cnt_q <= scan_cnt_q + 16'h1;
         end
         SEG      <= seg_d; // R6
         DIGIT_EN <= 4'(4'h1 << digit_q);
      end
   end
endmodule : fpk_keypad_menu
`default_nettype wire

/* File: include/fpk_pkg.sv */
// Purpose: shared constants for the front panel keypad menu block
// Assumes: 50 MHz clock, AHB-Lite register access
// Notes:   offsets are byte addresses of word registers
`default_nettype none
package fpk_pkg;
   // ************************************************************
   // register map
   // ************************************************************
   localparam logic [7:0] OFS_CTRL   = 8'h00; // control: source, direction, pot, trip
   localparam logic [7:0] OFS_STATUS = 8'h04; // status: mode, leds, unstored-edit flag
   localparam logic [7:0] OFS_VALUE  = 8'h08; // committed value of selected code
   localparam logic [7:0] OFS_CODE   = 8'h0c; // current code group and index
   localparam logic [7:0] OFS_LIVE   = 8'h10; // monitored frequency
   // control fields
   localparam int CTRL_SRC_LSB  = 0;  // run command source, 2 bits
   localparam int CTRL_DIR_BIT  = 2;  // run key direction, 1 = reverse
   localparam int CTRL_POT_BIT  = 3;  // knob selected for frequency
   localparam int CTRL_TRIP_BIT = 4;  // trip condition from motor core
   localparam int CTRL_RUN_BIT  = 5;  // output stage active
   localparam int CTRL_FLT_LSB  = 8;  // fault code, 4 bits
   // run command source encodings
   localparam logic [1:0] SRC_TERMINAL = 2'h1;
   localparam logic [1:0] SRC_KEYPAD   = 2'h2;
   localparam logic [1:0] SRC_NETWORK  = 2'h3;
   // function groups
   typedef enum logic [2:0] {
      GRP_D, GRP_F, GRP_A, GRP_B, GRP_C, GRP_H, GRP_E
   } fpk_grp_t;
   localparam logic [2:0] GRP_LAST = 3'h5; // last navigable group
   localparam logic [3:0] IDX_LAST = 4'hf; // codes per group minus one
   // seven-segment glyphs, gfedcba
   localparam logic [6:0] SEG_BLANK = 7'h00;
   localparam logic [6:0] SEG_ALL   = 7'h7f;
   // timing
   localparam int CLK_HZ       = 50_000_000;
   localparam int DEBOUNCE_MS  = 10;
   localparam int TEST_MS      = 500;
   localparam int SCAN_US      = 1000;
   localparam int SCAN_CYC     = CLK_HZ / 1_000_000 * SCAN_US;
endpackage : fpk_pkg
`default_nettype wire
